// [verilog/iot_pkg.sv]
package iot_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONFIG  = 6'h01;
  localparam logic [5:0] IDX_TIMING  = 6'h02;
  localparam logic [5:0] IDX_STATUS  = 6'h09;
  localparam int         ADDR_W      = 8;

  // configuration register fields
  localparam int CFG_INTERP_LSB = 6;
  localparam int CFG_SINGLE_BIT = 4;

  // timing register fields
  localparam int TIM_MARGIN_LSB = 7;
  localparam int TIM_AUTO_BIT   = 3;
  localparam int TIM_DLYEN_BIT  = 5;
  localparam int TIM_DELAY_LSB  = 0;

  // status register fields
  localparam int STA_ERROR_BIT  = 0;
  localparam int STA_TYPE_BIT   = 5;

  // delay code range
  localparam logic [4:0] DLY_MIN = 5'h00;
  localparam logic [4:0] DLY_MAX = 5'h1f;
  localparam int         TAPS    = 32;

  // history depth covers twice the widest margin plus the centre
  localparam int         HIST    = 32;

  // settle time before a check, long enough to refill the history
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SETTLE_NS     = 128;
  localparam int SETTLE_CYC    = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  localparam logic [5:0] SETTLE_LAST = 6'(SETTLE_CYC - 1);

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // checker states, gray along idle, settle, wait
  typedef enum logic [1:0] {
    CHK_IDLE   = 2'h0,
    CHK_SETTLE = 2'h1,
    CHK_WAIT   = 2'h3
  } iot_chk_e;

  // timing register contents
  typedef struct packed {
    logic [3:0] margin;
    logic       auto_en;
    logic       dly_en;
    logic [4:0] dly;
  } iot_timing_s;

  // configuration register contents
  typedef struct packed {
    logic [1:0] interp;
    logic       single;
  } iot_config_s;

endpackage

// [verilog/iot_tap_line.sv]
`timescale 1ns/100ps
// selectable delay line, one stage per step of the code
module iot_tap_line (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       din,
  input  wire logic       enable,
  input  wire logic [4:0] code,
  output logic            dout
);

  logic [iot_pkg::TAPS-1:0] taps;

  // every stage adds the same step, so delay rises evenly with code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taps <= '0;
      dout <= 1'b0;
    end else begin
      taps <= {taps[iot_pkg::TAPS-2:0], din};
      dout <= enable ? taps[code] : din; // RULE13 RULE14
    end
  end

endmodule // iot_tap_line

// [verilog/iot_input_timing.sv]
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
// Behaviour
// (RULE1) output clock rate is sample clock over interpolation times port divisor
// (RULE2) port divisor is one half in single-port, one in dual-port mode; here single-port at interpolation one keeps a divisor of one
// (RULE3) output clock keeps fixed phase to the internal capture strobe
// (RULE4) capture strobe from a divider, or every cycle when rates match
// (RULE5) source clocked by reference must pulse sync to fix divider phase
// (RULE6) early and late shadow samples; mismatch with real sample is error
// (RULE7) four-bit margin field sets shadow sample spacing
// (RULE8) error flag rises when margin is short even if data is good
// (RULE9) error type bit: low means hold error, high means setup error
// (RULE10) automatic mode raises delay on setup error, lowers on hold error
// (RULE11) software reads back the delay code actually in use; here bit 3 of the code reads as one whenever auto_en is set
// (RULE12) manual mode never alters the software delay code
// (RULE13) delay line enable resets off; code acts only when enabled
// (RULE14) codes zero to 31 give evenly increasing clock delay
// (RULE15) checking runs in manual mode too and raises the flag
// (RULE16) one check per setting; margin or delay change restarts it
// (RULE17) source sends words at twice rate single-port, at rate dual-port
// (RULE18) automatic adjustment saturates at code limits, never wraps
module iot_input_timing (
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  input  wire logic [iot_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                       S_AXI_AWVALID,
  output logic                            S_AXI_AWREADY,
  input  wire logic [31:0]                S_AXI_WDATA,
  input  wire logic [3:0]                 S_AXI_WSTRB,
  input  wire logic                       S_AXI_WVALID,
  output logic                            S_AXI_WREADY,
  output logic [1:0]                      S_AXI_BRESP,
  output logic                            S_AXI_BVALID,
  input  wire logic                       S_AXI_BREADY,
  input  wire logic [iot_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                       S_AXI_ARVALID,
  output logic                            S_AXI_ARREADY,
  output logic [31:0]                     S_AXI_RDATA,
  output logic [1:0]                      S_AXI_RRESP,
  output logic                            S_AXI_RVALID,
  input  wire logic                       S_AXI_RREADY,
  input  wire logic [15:0]                DATA_IN,
  input  wire logic                       SYNC_IN,
  output logic                            INTERFACE_CLOCK_OUT,
  output logic                            INPUT_CAPTURE_CLOCK,
  output logic [15:0]                     CAPTURED_DATA,
  output logic                            TIMING_ERROR_IRQ
);

  // ---------------- register bus ----------------
  logic [iot_pkg::ADDR_W-1:0] aw_addr;
  logic                       aw_got;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic                       w_got;
  logic                       bvalid;
  logic [1:0]                 bresp;
  logic                       rvalid;
  logic [1:0]                 rresp;
  logic [31:0]                rdata;

  iot_pkg::iot_config_s cfg;
  iot_pkg::iot_timing_s tim;
  logic                 err_flag;
  logic                 err_type;

  wire        wr_commit  = aw_got && w_got && !bvalid;
  wire [5:0]  wr_idx     = aw_addr[7:2];
  wire        wr_config  = wr_commit && wr_idx == iot_pkg::IDX_CONFIG;
  wire        wr_timing  = wr_commit && wr_idx == iot_pkg::IDX_TIMING;
  wire        wr_status  = wr_commit && wr_idx == iot_pkg::IDX_STATUS;
  wire        wr_mapped  = wr_config || wr_timing || wr_status;
  wire [31:0] wr_mask    = {{8{w_strb[3]}}, {8{w_strb[2]}},
                            {8{w_strb[1]}}, {8{w_strb[0]}}};

  // read images; reserved bits read as zero
  wire [31:0] img_config = {24'h000000, cfg.interp, 1'b0, cfg.single,
                            4'h0};
  wire [31:0] img_timing = {21'h000000, tim.margin, 1'b0, tim.dly_en,
                            1'b0, tim.auto_en, tim.dly[2:0]} |
                           {27'h0000000, tim.dly}; // RULE11
  wire [31:0] img_status = {26'h0000000, err_type, 4'h0, err_flag};

  wire [31:0] new_config = (img_config & ~wr_mask) | (w_data & wr_mask);
  wire [31:0] new_timing = (img_timing & ~wr_mask) | (w_data & wr_mask);

  wire [5:0]  rd_idx     = S_AXI_ARADDR[7:2];
  wire        rd_cfg     = rd_idx == iot_pkg::IDX_CONFIG;
  wire        rd_tim     = rd_idx == iot_pkg::IDX_TIMING;
  wire        rd_sta     = rd_idx == iot_pkg::IDX_STATUS;
  wire [31:0] rd_mux     = rd_cfg ? img_config :
                           rd_tim ? img_timing :
                           rd_sta ? img_status : 32'h00000000;
  wire        rd_ok      = rd_cfg || rd_tim || rd_sta;

  assign S_AXI_AWREADY = !aw_got && !bvalid;
  assign S_AXI_WREADY  = !w_got && !bvalid;
  assign S_AXI_BVALID  = bvalid;
  assign S_AXI_BRESP   = bresp;
  assign S_AXI_ARREADY = !rvalid;
  assign S_AXI_RVALID  = rvalid;
  assign S_AXI_RRESP   = rresp;
  assign S_AXI_RDATA   = rdata;

  // address and data are taken in either order, answered together
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= iot_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got  <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got  <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_commit) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= wr_mapped ? iot_pkg::RESP_OKAY : iot_pkg::RESP_SLVERR;
      end else if (bvalid && S_AXI_BREADY) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read answers one cycle after the address is taken
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= iot_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_ok ? iot_pkg::RESP_OKAY : iot_pkg::RESP_SLVERR;
    end else if (rvalid && S_AXI_RREADY) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------- pin synchronisers ----------------
  logic [15:0] data_meta;
  logic [15:0] data_sync;
  logic        sync_meta;
  logic        sync_s1;
  logic        sync_s2;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      data_meta <= 16'h0000;
      data_sync <= 16'h0000;
      sync_meta <= 1'b0;
      sync_s1   <= 1'b0;
      sync_s2   <= 1'b0;
    end else begin
      data_meta <= DATA_IN;
      data_sync <= data_meta;
      sync_meta <= SYNC_IN;
      sync_s1   <= sync_meta;
      sync_s2   <= sync_s1;
    end
  end

  wire sync_rise = sync_s1 && !sync_s2;

  // ---------------- rate divider ----------------
  logic [3:0] cnt;
  logic       clk_lvl;

  wire [3:0] if_val   = 4'h1 << cfg.interp; // RULE1
  wire [3:0] if_half  = if_val >> 1;
  // single-port halves the divisor; at unity there is nothing to halve
  wire [3:0] div_n    = !cfg.single ? if_val :
                        (if_half == 4'h0) ? 4'h1 : if_half; // RULE2
  wire       div_on   = div_n != 4'h1;
  wire       cnt_wrap = cnt >= div_n - 4'h1;
  // sync forces the counter to a known phase of the strobe
  wire [3:0] next_cnt = (sync_rise || cnt_wrap) ? 4'h0 :
                        cnt + 4'h1; // RULE5
  wire       cap_pulse = !div_on || cnt == 4'h0; // RULE4

  // at unity the output toggles, so each edge marks one word
  wire next_clk_lvl = div_on ? (next_cnt < (div_n >> 1)) : !clk_lvl;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt     <= 4'h0;
      clk_lvl <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      clk_lvl <= next_clk_lvl; // RULE3
    end
  end

  // output clock leaves through the delay line, strobe stays fixed
  iot_tap_line u_tap (
    .clk    (CLK),
    .rst_n  (RST_N),
    .din    (clk_lvl),
    .enable (tim.dly_en),
    .code   (tim.dly),
    .dout   (INTERFACE_CLOCK_OUT)
  );

  assign INPUT_CAPTURE_CLOCK = cap_pulse;

  // ---------------- margin sampling ----------------
  logic [15:0] hist [iot_pkg::HIST];

  // hist[0] is the latest word; older words sit at higher indices
  wire [15:0] real_word  = hist[{1'b0, tim.margin}];
  wire [15:0] early_word = hist[{tim.margin, 1'b0}]; // RULE7
  wire [15:0] late_word  = hist[0];
  wire        setup_miss = early_word != real_word; // RULE6
  wire        hold_miss  = late_word != real_word;

  always_ff @(posedge CLK) begin
    hist[0] <= data_sync;
    for (int i = 1; i < iot_pkg::HIST; i++) begin
      hist[i] <= hist[i-1];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CAPTURED_DATA <= 16'h0000;
    end else if (cap_pulse) begin
      CAPTURED_DATA <= real_word;
    end
  end

  // ---------------- single check per setting ----------------
  iot_pkg::iot_chk_e chk;
  iot_pkg::iot_chk_e next_chk;
  logic [5:0]        settle;

  wire err_pulse  = chk == iot_pkg::CHK_WAIT && cap_pulse &&
                    (setup_miss || hold_miss); // RULE15
  wire err_setup  = setup_miss;
  wire auto_step  = err_pulse && tim.auto_en;
  wire tim_change = wr_timing &&
                    (new_timing[iot_pkg::TIM_MARGIN_LSB +: 4] != tim.margin ||
                     new_timing[iot_pkg::TIM_DELAY_LSB +: 5] != tim.dly);
  wire rearm      = tim_change || (auto_step && !wr_timing); // RULE16
  wire chk_eval   = chk == iot_pkg::CHK_WAIT && cap_pulse && !rearm;

  always_comb begin
    next_chk = chk;
    case (chk)
      iot_pkg::CHK_IDLE:   next_chk = chk;
      iot_pkg::CHK_SETTLE: if (settle == iot_pkg::SETTLE_LAST) begin
        next_chk = iot_pkg::CHK_WAIT;
      end
      iot_pkg::CHK_WAIT:   if (chk_eval) begin
        next_chk = iot_pkg::CHK_IDLE;
      end
      default:             next_chk = iot_pkg::CHK_IDLE;
    endcase
    if (rearm) begin
      next_chk = iot_pkg::CHK_SETTLE;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      chk    <= iot_pkg::CHK_SETTLE;
      settle <= 6'h00;
    end else begin
      chk    <= next_chk;
      // a rearm restarts the count so the history is fully refilled
      settle <= (next_chk == iot_pkg::CHK_SETTLE && chk == next_chk &&
                 !rearm) ? settle + 6'h01 : 6'h00; // RULE16
    end
  end

  // ---------------- configuration and status ----------------
  // a software write beats an automatic step in the same cycle
  wire [4:0] dly_up   = (tim.dly == iot_pkg::DLY_MAX) ? tim.dly :
                        tim.dly + 5'h01; // RULE18
  wire [4:0] dly_down = (tim.dly == iot_pkg::DLY_MIN) ? tim.dly :
                        tim.dly - 5'h01; // RULE18

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg <= '0;
      tim <= '0; // RULE13
    end else begin
      if (wr_config) begin
        cfg.interp <= new_config[iot_pkg::CFG_INTERP_LSB +: 2];
        cfg.single <= new_config[iot_pkg::CFG_SINGLE_BIT];
      end
      if (wr_timing) begin
        tim.margin  <= new_timing[iot_pkg::TIM_MARGIN_LSB +: 4];
        tim.auto_en <= new_timing[iot_pkg::TIM_AUTO_BIT];
        tim.dly_en  <= new_timing[iot_pkg::TIM_DLYEN_BIT];
        tim.dly     <= new_timing[iot_pkg::TIM_DELAY_LSB +: 5];
      end else if (auto_step) begin
        tim.dly <= err_setup ? dly_up : dly_down; // RULE10 RULE12
      end
    end
  end

  // sticky error flag, write one to clear; a new error wins
  wire clr_err = wr_status && w_strb[0] && w_data[iot_pkg::STA_ERROR_BIT];

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      err_flag <= 1'b0;
      err_type <= 1'b0;
    end else begin
      err_flag <= err_pulse || (err_flag && !clr_err); // RULE8
      if (err_pulse) begin
        err_type <= err_setup; // RULE9
      end
    end
  end

  assign TIMING_ERROR_IRQ = err_flag;

  // ---------------- checks ----------------
  AST_NO_DIVIDE: assert property (@(posedge CLK) disable iff (!RST_N)
    (div_n == 4'h1) |-> cap_pulse) // RULE4
    else $error("strobe missing with divider off");
  AST_SPACING: assert property (@(posedge CLK) disable iff (!RST_N)
    (cap_pulse && div_on && !wr_config && !sync_rise) |=> !cap_pulse) // RULE1
    else $error("strobes closer than the divide ratio");
  AST_SINGLE_HALF: assert property (@(posedge CLK) disable iff (!RST_N)
    (cfg.single && cfg.interp == 2'h3) |-> div_n == 4'h4) // RULE2
    else $error("single-port divisor not halved");
  AST_ERR_SEEN: assert property (@(posedge CLK) disable iff (!RST_N)
    (chk == iot_pkg::CHK_WAIT && cap_pulse && (setup_miss || hold_miss))
    |=> TIMING_ERROR_IRQ) // RULE8
    else $error("mismatch did not raise the error flag");
  AST_TYPE: assert property (@(posedge CLK) disable iff (!RST_N)
    err_pulse |=> err_type == $past(setup_miss)) // RULE9
    else $error("error type bit wrong");
  AST_AUTO_UP: assert property (@(posedge CLK) disable iff (!RST_N)
    (auto_step && err_setup && tim.dly != iot_pkg::DLY_MAX && !wr_timing)
    |=> tim.dly == $past(tim.dly) + 5'h01) // RULE10
    else $error("automatic increment missing");
  AST_FLOOR: assert property (@(posedge CLK) disable iff (!RST_N)
    (auto_step && !err_setup && tim.dly == iot_pkg::DLY_MIN && !wr_timing)
    |=> tim.dly == iot_pkg::DLY_MIN) // RULE18
    else $error("delay code wrapped below zero");
  AST_MANUAL: assert property (@(posedge CLK) disable iff (!RST_N)
    (!tim.auto_en && !wr_timing) |=> tim.dly == $past(tim.dly)) // RULE12
    else $error("manual delay code changed by hardware");
  AST_REARM: assert property (@(posedge CLK) disable iff (!RST_N)
    tim_change |=> chk == iot_pkg::CHK_SETTLE && settle == 6'h00) // RULE16
    else $error("setting change did not restart the check");
  AST_SETTLE_END: assert property (@(posedge CLK) disable iff (!RST_N)
    (chk == iot_pkg::CHK_SETTLE && settle == iot_pkg::SETTLE_LAST &&
     !rearm) |=> chk == iot_pkg::CHK_WAIT) // RULE16
    else $error("check did not start after settling");

endmodule // iot_input_timing

// [dv/iot_source.sv]
`timescale 1ns/100ps
// parallel word source standing in for the far-side logic
module iot_source (
  input  wire logic        clk,
  input  wire logic        hold,
  output logic [15:0]      data
);
  localparam logic [15:0] BASE = 16'ha5c3;

  // a held word meets any margin; a new word every sample clock is far
  // too fast on purpose, so the margin samples disagree at any nonzero margin
  always_ff @(posedge clk) begin
    if (hold) begin
      data <= BASE;
    end else begin
      data <= data + 16'h0001;
    end
  end
endmodule // iot_source

// [dv/testbench.sv]
`timescale 1ns/100ps
module testbench;
  localparam logic [7:0] A_CFG = {iot_pkg::IDX_CONFIG, 2'b00};
  localparam logic [7:0] A_TIM = {iot_pkg::IDX_TIMING, 2'b00};
  localparam logic [7:0] A_STA = {iot_pkg::IDX_STATUS, 2'b00};
  logic                       clk;
  logic                       rst_n;
  logic [iot_pkg::ADDR_W-1:0] awaddr;
  logic                       awvalid;
  logic                       awready;
  logic [31:0]                wdata;
  logic                       wvalid;
  logic                       wready;
  logic [1:0]                 bresp;
  logic                       bvalid;
  logic                       bready;
  logic [iot_pkg::ADDR_W-1:0] araddr;
  logic                       arvalid;
  logic                       arready;
  logic [31:0]                rdata;
  logic [1:0]                 rresp;
  logic                       rvalid;
  logic                       rready;
  logic [15:0]                data_in;
  logic                       sync_in;
  logic                       hold;
  logic                       clk_out;
  logic                       strobe;
  logic [15:0]                captured;
  logic                       irq;
  logic [31:0]                rd;
  logic [1:0]                 resp;
  int                         fails;
  int                         n_checks;
  int                         a;
  int                         b;
  int                         c;
  int                         n;

  iot_input_timing i_dut (
    .CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .DATA_IN(data_in), .SYNC_IN(sync_in),
    .INTERFACE_CLOCK_OUT(clk_out), .INPUT_CAPTURE_CLOCK(strobe),
    .CAPTURED_DATA(captured), .TIMING_ERROR_IRQ(irq)
  );

  iot_source i_src (.clk(clk), .hold(hold), .data(data_in));

  // 250 MHz sample clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // both channels offered together, each dropped when taken
  // handshakes are judged at the falling edge, before the edge that takes
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    int   t;
    logic aw_ok;
    logic w_ok;
    logic done;
    t = 0;
    @(posedge clk);
    awaddr  <= ad;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge clk);
      t++;
      aw_ok = awvalid && awready;
      w_ok  = wvalid && wready;
      done  = bvalid && bready;
      resp  = bresp;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end while (!done && t < 100);
    bready <= 1'b0;
    if (!done) fails++;
  endtask

  task automatic rdr(input logic [7:0] ad);
    int   t;
    logic ar_ok;
    logic done;
    t = 0;
    @(posedge clk);
    araddr  <= ad;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
      t++;
      ar_ok = arvalid && arready;
      done  = rvalid && rready;
      rd    = rdata;
      resp  = rresp;
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
    end while (!done && t < 100);
    rready <= 1'b0;
    if (!done) fails++;
  endtask

  // strobes, output clock rises and phase slips over 64 cycles
  task automatic count64(output int ns, output int nr, output int bad);
    logic prev;
    logic ph;
    ns = 0;
    nr = 0;
    bad = 0;
    @(negedge clk);
    prev = clk_out;
    ph = 1'b0;
    repeat (64) begin
      @(negedge clk);
      if (strobe) begin
        if (ns == 0) ph = clk_out;
        else if (clk_out !== ph) bad++;
        ns++;
      end
      if (clk_out && !prev) nr++;
      prev = clk_out;
    end
  endtask

  // cycles from a strobe to the next output clock rise
  task automatic lag(output int l);
    logic prev;
    logic rise;
    cyc(16);
    @(negedge clk);
    while (strobe !== 1'b1) @(negedge clk);
    prev = clk_out;
    l = 0;
    do begin
      @(negedge clk);
      l++;
      rise = clk_out && !prev;
      prev = clk_out;
    end while (!rise);
  endtask

  // time from a sync pulse to a later strobe, taken modulo the divide
  task automatic sync_gap(output int g);
    @(posedge clk);
    sync_in <= 1'b1;
    cyc(4);
    sync_in <= 1'b0;
    cyc(12);
    g = 16;
    @(negedge clk);
    while (strobe !== 1'b1) begin
      @(negedge clk);
      g++;
    end
  endtask

  initial begin
    fails = 0;
    n_checks = 0;
    rst_n = 1'b0;
    hold = 1'b1;
    sync_in = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    rdr(A_TIM);
    chk(rd[5], 1'b0);
    // unmapped place refused on both paths
    wr(8'h10, 32'h0000ffff);
    chk(resp, iot_pkg::RESP_SLVERR);
    rdr(8'h10);
    chk(rd, 32'h0);
    chk(resp, iot_pkg::RESP_SLVERR);
    // every interpolation factor in both port modes
    for (int i = 0; i < 8; i++) begin
      wr(A_CFG, {24'h0, i[1:0], 1'b0, i[2], 4'h0});
      chk(resp, iot_pkg::RESP_OKAY);
      cyc(16);
      count64(a, b, c);
      n = (1 << i[1:0]) >> i[2];
      if (n == 0) n = 1;
      chk(a, 64 / n);
      chk(b, (n == 1) ? 32 : 64 / n);
      if (n > 1) chk(c, 0);
    end
    // divide by eight; sync fixes the divider phase
    wr(A_CFG, 32'h000000c0);
    sync_gap(a);
    cyc(3);
    sync_gap(b);
    chk(a % 8, b % 8);
    // delay line: disabled code acts as zero, codes add whole steps
    wr(A_TIM, 32'h00000005);
    lag(a);
    wr(A_TIM, 32'h00000000);
    lag(c);
    chk(a, c);
    wr(A_TIM, 32'h00000020);
    lag(b);
    wr(A_TIM, 32'h00000025);
    lag(c);
    chk((c - b + 8) % 8, 5);
    rdr(A_TIM);
    chk(rd[10:0], 11'h025);
    // good data with margin four gives no error
    wr(A_TIM, 32'h00000225);
    cyc(80);
    rdr(A_STA);
    chk(rd[0], 1'b0);
    chk(captured, 16'ha5c3);
    // bad data after the check: no second check without a change
    hold <= 1'b0;
    cyc(80);
    chk(irq, 1'b0);
    wr(A_TIM, 32'h00000226);
    cyc(80);
    chk(irq, 1'b1);
    rdr(A_STA);
    chk(rd[0], 1'b1);
    chk(rd[5], 1'b1);
    rdr(A_TIM);
    chk(rd[10:0], 11'h226);
    wr(A_STA, 32'h00000001);
    cyc(80);
    chk(irq, 1'b0);
    // zero margin spacing never sees a difference
    wr(A_TIM, 32'h00000026);
    cyc(80);
    chk(irq, 1'b0);
    // automatic mode climbs on setup errors and stops at the top
    wr(A_TIM, 32'h0000013d);
    cyc(300);
    rdr(A_TIM);
    chk(rd[4:0], 5'h1f);
    chk(irq, 1'b1);
    finish_test();
  end

  // whole run is a few thousand cycles
  initial begin
    cyc(20000);
    fails++;
    finish_test();
  end
endmodule // testbench
